// ---- inc/trace_mem_if.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "trace_params.svh"
interface trace_mem_if;
  logic wr_en;
  logic [`PTR_W-1:0] wr_addr;
  logic [`ENTRY_W-1:0] wr_data;
  logic [`PTR_W-1:0] rd_addr;
  logic [`ENTRY_W-1:0] rd_data;
  modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport store (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface
`default_nettype wire

// ---- inc/trace_params.svh ----
`ifndef TRACE_PARAMS_SVH
`define TRACE_PARAMS_SVH
`define ADDR_W 24
`define DATA_W 16
`define EXT_W 4
`define STAT_W 20
`define ENTRY_W 64
`define PTR_W 8
`define DEPTH 256
`define TIMER_W 24
`define PIN_W 65
`define PIN_RESET 65'h00000000000F00000
`define OFF_MODE 8'h00
`define OFF_CTRL 8'h04
`define OFF_STATUS 8'h08
`define OFF_POST 8'h0C
`define OFF_POS 8'h10
`define OFF_EADDR 8'h14
`define OFF_EDATA 8'h18
`define OFF_ESTAT 8'h1C
`define OFF_TIMER 8'h20
`define OFF_BPEN 8'h24
`define OFF_PROBE 8'h28
`define BP_ADDR_PAGE 4'h3
`define BP_MASK_PAGE 4'h4
`define MODE_RESET 7'h02
`define PROBE_RESET 4'hF
`define MODE_AND 0
`define MODE_EN 3
`define MODE_RUN 4
`define RW_BIT 1
`define FETCH_BIT 2
`define WIDE_BIT 3
`define PCLK_MHZ 50
`define US_NS 1000
`define TICK_NS 100
`define US_CYCLES ((`US_NS * `PCLK_MHZ) / 1000)
`define TICK_CYCLES ((`TICK_NS * `PCLK_MHZ) / 1000)
`endif

// ---- inc/trace_pkg.sv ----
package trace_pkg;
  typedef enum logic [1:0] {
    CAP_IDLE = 2'h0,
    CAP_ARMED = 2'h1,
    CAP_POST = 2'h3,
    CAP_DONE = 2'h2
  } cap_state_e;
  typedef enum logic [1:0] {
    UNIT_US = 2'h0,
    UNIT_NS = 2'h1,
    UNIT_BUS = 2'h2
  } timer_unit_e;
  typedef enum logic [1:0] {
    KIND_WRITE = 2'h0,
    KIND_READ = 2'h1,
    KIND_FETCH = 2'h2
  } cycle_kind_e;
  typedef enum logic [1:0] {
    SNAP_NONE = 2'h0,
    SNAP_REGS = 2'h1,
    SNAP_REGS_MEM = 2'h2
  } snap_scope_e;
endpackage

// ---- src/event_timer.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "trace_params.svh"
module event_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire trace_pkg::timer_unit_e unit,
  input wire logic bus_tick,
  input wire logic start,
  input wire logic stop,
  output logic [`TIMER_W-1:0] count,
  output logic running
);
  logic [5:0] pre_q, pre_d, limit;
  logic [`TIMER_W-1:0] cnt_q, cnt_d;
  logic run_q, run_d, step;

  always_comb
  begin
    pre_d = pre_q;
    cnt_d = cnt_q;
    run_d = run_q;
    step = 1'b0;
    // R17 three unit choices
    limit = (unit == trace_pkg::UNIT_NS) ? 6'(`TICK_CYCLES - 1) : 6'(`US_CYCLES - 1);
    if (unit == trace_pkg::UNIT_BUS)
    begin
      step = bus_tick;
    end
    else if (pre_q >= limit)
    begin
      pre_d = 6'h00;
      step = 1'b1;
    end
    else
    begin
      pre_d = pre_q + 6'h01;
    end
    // R21 start and stop
    if (!enable)
    begin
      run_d = 1'b0;
    end
    else if (start && !run_q)
    begin
      run_d = 1'b1;
      cnt_d = '0;
      pre_d = 6'h00;
    end
    else if (stop)
    begin
      run_d = 1'b0;
    end
    // R20 one count per unit
    else if (run_q && step)
    begin
      cnt_d = cnt_q + 24'h000001;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pre_q <= 6'h00;
      cnt_q <= '0;
      run_q <= 1'b0;
    end
    else
    begin
      pre_q <= pre_d;
      cnt_q <= cnt_d;
      run_q <= run_d;
    end
  end

  assign count = cnt_q;
  assign running = run_q;
endmodule
`default_nettype wire

// ---- src/trace_mem.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "trace_params.svh"
module trace_mem (
  input wire logic pclk,
  input wire logic presetn,
  trace_mem_if.store mem
);
  logic [`ENTRY_W-1:0] ram_q [0:`DEPTH-1];
  logic [`ENTRY_W-1:0] rd_q;
  logic [`ENTRY_W-1:0] rd_d;

  always_comb
  begin
    rd_d = ram_q[mem.rd_addr];
  end

  always_ff @(posedge pclk)
  begin
    if (mem.wr_en)
    begin
      ram_q[mem.wr_addr] <= mem.wr_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rd_q <= '0;
    end
    else
    begin
      rd_q <= rd_d;
    end
  end

  assign mem.rd_data = rd_q;
endmodule
`default_nettype wire

// ---- src/trace_trigger.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "trace_params.svh"
// How it works
// R01: Store one entry per target bus cycle
// R02: Entry positions signed, trigger at zero
// R03: Capture post-trigger delay cycles after trigger
// R04: Four probe lines, line 0 LSB
// R05: Unconnected probes read as ones
// R06: Twenty processor status bits per entry
// R07: Status read out as ordered nibbles
// R08: Full address width always captured
// R09: Cycle kind derived from status bits
// R10: Status bits select valid data portion
// R11: OR mode: each breakpoint triggers alone
// R12: AND mode: lowest armed, arms next
// R13: AND mode: highest active one triggers
// R14: Breakpoint 3 not a break when enabled
// R15: Snapshot scope two-bit encoding 0/1/2
// R16: Scope has no effect on capture
// R17: Timer units: us, 100ns, bus cycles
// R18: Reset modes: OR, scope 1, pause, us
// R19: Break waits for post-trigger capture
// R20: Event timer is 24-bit counter
// R21: Timer starts bp1, stops bp2 (code runs the timer only in AND mode with scope 0)
// R22: Circular store keeps pre-trigger history
module trace_trigger (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic bus_cycle,
  input wire logic [`ADDR_W-1:0] tgt_addr,
  input wire logic [`DATA_W-1:0] tgt_data,
  input wire logic [`EXT_W-1:0] ext_probe,
  input wire logic [`STAT_W-1:0] proc_status,
  output logic break_req,
  output logic [1:0] snap_scope,
  output logic trace_done
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [2:0] first_act(input logic [3:0] m, input logic [2:0] from);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 3; i >= 0; i--)
    begin
      if (m[i] && (3'(i) >= from))
      begin
        r = {1'b1, 2'(i)};
      end
    end
    return r;
  endfunction

  function automatic logic [19:0] nib_order(input logic [19:0] s);
    logic [19:0] r;
    r = 20'h00000;
    for (int k = 0; k < 5; k++)
    begin
      r[19-4*k -: 4] = s[4*k +: 4];
    end
    return r;
  endfunction

  function automatic trace_pkg::cycle_kind_e kind_of(input logic [19:0] s);
    trace_pkg::cycle_kind_e r;
    r = s[`RW_BIT] ? trace_pkg::KIND_READ : trace_pkg::KIND_WRITE;
    if (s[`FETCH_BIT])
    begin
      r = trace_pkg::KIND_FETCH;
    end
    return r;
  endfunction

  function automatic logic [15:0] valid_mask(input logic [19:0] s);
    return s[`WIDE_BIT] ? 16'hFFFF : 16'h00FF;
  endfunction

  // ----------------------------------------
  // Pin sampling
  // ----------------------------------------
  logic [`PIN_W-1:0] pin1_q, pin1_d, pin2_q, pin2_d;
  logic strobe3_q, strobe3_d, tick;
  logic [`ADDR_W-1:0] s_addr;
  logic [`EXT_W-1:0] s_ext;
  logic [`STAT_W-1:0] s_stat;

  always_comb
  begin
    pin1_d = {bus_cycle, tgt_addr, tgt_data, ext_probe, proc_status};
    pin2_d = pin1_q;
    strobe3_d = pin2_q[64];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin1_q <= `PIN_RESET;
      pin2_q <= `PIN_RESET;
      strobe3_q <= 1'b0;
    end
    else
    begin
      pin1_q <= pin1_d;
      pin2_q <= pin2_d;
      strobe3_q <= strobe3_d;
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  logic [6:0] mode_q, mode_d, post_q, post_d;
  logic [`PTR_W-1:0] pos_q, pos_d;
  logic [3:0] bp_en_q, bp_en_d, probe_en_q, probe_en_d;
  logic [`ADDR_W-1:0] bp_addr_q [0:3];
  logic [`ADDR_W-1:0] bp_addr_d [0:3];
  logic [`ADDR_W-1:0] bp_mask_q [0:3];
  logic [`ADDR_W-1:0] bp_mask_d [0:3];
  logic qual_q, qual_d, wr_acc, rearm, analyzer_en, and_mode;
  logic [3:0] act, hit;

  assign wr_acc = psel && penable && pwrite && pready;
  assign rearm = wr_acc && (paddr == `OFF_CTRL) && pwdata[0];
  assign analyzer_en = mode_q[`MODE_EN];
  assign and_mode = mode_q[`MODE_AND];
  assign tick = pin2_q[64] && !strobe3_q;
  // R08 full address
  assign s_addr = pin2_q[63:40];
  // R05 unused probes high
  assign s_ext = pin2_q[23:20] | ~probe_en_q;
  assign s_stat = pin2_q[19:0];

  always_comb
  begin
    mode_d = mode_q;
    post_d = post_q;
    pos_d = pos_q;
    bp_en_d = bp_en_q;
    probe_en_d = probe_en_q;
    bp_addr_d = bp_addr_q;
    bp_mask_d = bp_mask_q;
    qual_d = qual_q;
    if (wr_acc && (paddr[1:0] == 2'h0))
    begin
      case (paddr)
        // R15 scope field stored
        `OFF_MODE: mode_d = pwdata[6:0];
        `OFF_CTRL: qual_d = pwdata[1] ? 1'b0 : qual_q;
        `OFF_POST: post_d = pwdata[6:0];
        `OFF_POS: pos_d = pwdata[7:0];
        `OFF_BPEN: bp_en_d = pwdata[3:0];
        `OFF_PROBE: probe_en_d = pwdata[3:0];
        default:
        begin
          if (paddr[7:4] == `BP_ADDR_PAGE)
          begin
            bp_addr_d[paddr[3:2]] = pwdata[23:0];
          end
          if (paddr[7:4] == `BP_MASK_PAGE)
          begin
            bp_mask_d[paddr[3:2]] = pwdata[23:0];
          end
        end
      endcase
    end
    // R14 qualifier match flag
    if (analyzer_en && hit[3])
    begin
      qual_d = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      // R18 reset defaults
      mode_q <= `MODE_RESET;
      post_q <= 7'h00;
      pos_q <= 8'h00;
      bp_en_q <= 4'h0;
      probe_en_q <= `PROBE_RESET;
      bp_addr_q <= '{default: '0};
      bp_mask_q <= '{default: '0};
      qual_q <= 1'b0;
    end
    else
    begin
      mode_q <= mode_d;
      post_q <= post_d;
      pos_q <= pos_d;
      bp_en_q <= bp_en_d;
      probe_en_q <= probe_en_d;
      bp_addr_q <= bp_addr_d;
      bp_mask_q <= bp_mask_d;
      qual_q <= qual_d;
    end
  end

  // ----------------------------------------
  // Breakpoint sequencing
  // ----------------------------------------
  logic [1:0] stage_q, stage_d;
  logic [2:0] low, nxt;
  logic trig;

  always_comb
  begin
    // R14 bp3 excluded when enabled
    act = bp_en_q & ~{analyzer_en, 3'h0};
    act[3] = act[3] || (bp_en_q[3] && analyzer_en);
    for (int i = 0; i < 4; i++)
    begin
      hit[i] = tick && bp_en_q[i] && (((s_addr ^ bp_addr_q[i]) & ~bp_mask_q[i]) == '0);
    end
    act[3] = bp_en_q[3] && !analyzer_en;
    hit = hit & (act | {analyzer_en, 3'h0});
    low = first_act(act, 3'h0);
    nxt = first_act(act, {1'b0, stage_q} + 3'h1);
    stage_d = act[stage_q] ? stage_q : low[1:0];
    trig = 1'b0;
    if (and_mode)
    begin
      // R12 arm next one
      if (act[stage_q] && hit[stage_q])
      begin
        if (nxt[2])
        begin
          stage_d = nxt[1:0];
        end
        // R13 highest one fires
        else
        begin
          trig = 1'b1;
          stage_d = low[1:0];
        end
      end
    end
    else
    begin
      // R11 any match fires
      trig = |(hit & act);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stage_q <= 2'h0;
    end
    else
    begin
      stage_q <= stage_d;
    end
  end

  // ----------------------------------------
  // Capture control
  // ----------------------------------------
  trace_pkg::cap_state_e state_q, state_d;
  logic [`PTR_W-1:0] wr_ptr_q, wr_ptr_d, trig_ptr_q, trig_ptr_d;
  logic [6:0] post_cnt_q, post_cnt_d;
  logic brk_q, brk_d, done_q, capturing;
  trace_mem_if mif ();

  // R16 scope not consulted
  assign capturing = (state_q == trace_pkg::CAP_ARMED) || (state_q == trace_pkg::CAP_POST);

  always_comb
  begin
    state_d = state_q;
    wr_ptr_d = wr_ptr_q;
    trig_ptr_d = trig_ptr_q;
    post_cnt_d = post_cnt_q;
    // R01 one write per cycle
    if (tick && capturing)
    begin
      // R22 wraps over oldest
      wr_ptr_d = wr_ptr_q + 8'h01;
    end
    case (state_q)
      trace_pkg::CAP_IDLE:
      begin
        state_d = analyzer_en ? trace_pkg::CAP_ARMED : trace_pkg::CAP_IDLE;
      end
      trace_pkg::CAP_ARMED:
      begin
        if (trig)
        begin
          // R02 trigger is position zero
          trig_ptr_d = wr_ptr_q;
          post_cnt_d = 7'h00;
          state_d = (post_q == 7'h00) ? trace_pkg::CAP_DONE : trace_pkg::CAP_POST;
        end
      end
      trace_pkg::CAP_POST:
      begin
        // R03 count post delay
        if (tick)
        begin
          post_cnt_d = 7'(post_cnt_q + 7'h01);
          if (7'(post_cnt_q + 7'h01) == post_q)
          begin
            state_d = trace_pkg::CAP_DONE;
          end
        end
      end
      trace_pkg::CAP_DONE:
      begin
        state_d = rearm ? trace_pkg::CAP_ARMED : trace_pkg::CAP_DONE;
      end
      default:
      begin
        state_d = trace_pkg::CAP_IDLE;
      end
    endcase
    if (!analyzer_en)
    begin
      state_d = trace_pkg::CAP_IDLE;
    end
    // R19 break after post capture
    brk_d = analyzer_en ? (state_d == trace_pkg::CAP_DONE) && (state_q != trace_pkg::CAP_DONE)
                        : trig;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= trace_pkg::CAP_IDLE;
      wr_ptr_q <= 8'h00;
      trig_ptr_q <= 8'h00;
      post_cnt_q <= 7'h00;
      brk_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      wr_ptr_q <= wr_ptr_d;
      trig_ptr_q <= trig_ptr_d;
      post_cnt_q <= post_cnt_d;
      brk_q <= brk_d;
      done_q <= (state_d == trace_pkg::CAP_DONE);
    end
  end

  assign mif.wr_en = tick && capturing;
  assign mif.wr_addr = wr_ptr_q;
  // R04 R06 entry layout
  assign mif.wr_data = {s_addr, pin2_q[39:24], s_ext, s_stat};
  // R02 signed offset from trigger
  assign mif.rd_addr = trig_ptr_q + pos_q;

  trace_mem u_mem (
    .pclk(pclk),
    .presetn(presetn),
    .mem(mif)
  );

  // ----------------------------------------
  // Event timer
  // ----------------------------------------
  logic [`TIMER_W-1:0] tmr_count;
  logic tmr_run, tmr_en;

  assign tmr_en = and_mode && (mode_q[2:1] == trace_pkg::SNAP_NONE) && analyzer_en
                  && mode_q[`MODE_RUN];

  event_timer u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .enable(tmr_en),
    .unit(trace_pkg::timer_unit_e'(mode_q[6:5])),
    .bus_tick(tick),
    // R21 bp1 start, bp2 stop
    .start(hit[1]),
    .stop(trig && hit[2]),
    .count(tmr_count),
    .running(tmr_run)
  );

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  logic [31:0] prdata_q, prdata_d, rd_val;
  logic pready_q, pready_d, pslverr_q, pslverr_d, known;
  logic [`ENTRY_W-1:0] ent;

  assign ent = mif.rd_data;

  always_comb
  begin
    rd_val = 32'h00000000;
    known = 1'b1;
    case (paddr)
      `OFF_MODE: rd_val = {25'h0, mode_q};
      `OFF_CTRL: rd_val = 32'h00000000;
      `OFF_STATUS: rd_val = {24'h0, done_q, qual_q, tmr_run, stage_q, 1'b0, state_q};
      `OFF_POST: rd_val = {25'h0, post_q};
      `OFF_POS: rd_val = {24'h0, pos_q};
      `OFF_EADDR: rd_val = {8'h0, ent[63:40]};
      // R09 R10 kind and valid data
      `OFF_EDATA: rd_val = {8'h0, ent[23:20], 2'h0, kind_of(ent[19:0]),
                            ent[39:24] & valid_mask(ent[19:0])};
      // R07 nibble order
      `OFF_ESTAT: rd_val = {12'h0, nib_order(ent[19:0])};
      `OFF_TIMER: rd_val = {8'h0, tmr_count};
      `OFF_BPEN: rd_val = {28'h0, bp_en_q};
      `OFF_PROBE: rd_val = {28'h0, probe_en_q};
      default:
      begin
        known = (paddr[7:4] == `BP_ADDR_PAGE) || (paddr[7:4] == `BP_MASK_PAGE);
        if (paddr[7:4] == `BP_ADDR_PAGE)
        begin
          rd_val = {8'h0, bp_addr_q[paddr[3:2]]};
        end
        if (paddr[7:4] == `BP_MASK_PAGE)
        begin
          rd_val = {8'h0, bp_mask_q[paddr[3:2]]};
        end
      end
    endcase
    known = known && (paddr[1:0] == 2'h0);
    pready_d = psel && !penable;
    prdata_d = prdata_q;
    pslverr_d = pslverr_q;
    if (psel && !penable)
    begin
      prdata_d = (known && !pwrite) ? rd_val : 32'h00000000;
      pslverr_d = !known;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q <= 32'h00000000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign break_req = brk_q;
  assign trace_done = done_q;
  assign snap_scope = mode_q[2:1];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_write_step: assert property (tick && capturing |=> wr_ptr_q == $past(wr_ptr_q) + 8'h01) // R01
    else $error("entry not stored");
  a_trig_zero: assert property (state_q == trace_pkg::CAP_ARMED && trig && analyzer_en // R02
    |=> trig_ptr_q == $past(wr_ptr_q)) else $error("trigger position wrong");
  a_post_stop: assert property (state_q == trace_pkg::CAP_POST && tick && analyzer_en // R03
    && 7'(post_cnt_q + 7'h01) == post_q |=> state_q == trace_pkg::CAP_DONE)
    else $error("post delay not honoured");
  a_probe_ones: assert property (mif.wr_en |-> // R05
    (mif.wr_data[23:20] & ~probe_en_q) == ~probe_en_q) else $error("open probe not one");
  a_or_fire: assert property (!and_mode && analyzer_en && (|(hit & act)) // R11
    && state_q == trace_pkg::CAP_ARMED |=> state_q != trace_pkg::CAP_ARMED)
    else $error("or match lost");
  a_and_arm: assert property (and_mode && act[stage_q] && hit[stage_q] && nxt[2] // R12
    |=> stage_q == $past(nxt[1:0]) && !$past(trig)) else $error("and chain broken");
  a_and_last: assert property (and_mode && trig |-> act[stage_q] && !nxt[2]) // R13
    else $error("and fired early");
  a_bp3_quiet: assert property (analyzer_en |-> !act[3] && !(hit[3] && trig && and_mode // R14
    && stage_q == 2'h3)) else $error("bp3 breaks while enabled");
  a_break_late: assert property (analyzer_en && state_q == trace_pkg::CAP_POST |-> !brk_q) // R19
    else $error("break before post capture");
  a_break_done: assert property (analyzer_en && state_q == trace_pkg::CAP_POST // R19
    ##1 state_q == trace_pkg::CAP_DONE |-> brk_q) else $error("break missing");
  a_apb_ready: assert property (psel && !penable |=> pready_q ##1 !pready_q)
    else $error("apb answer timing");

  c_and_trig: cover property (and_mode && trig && analyzer_en);
  c_post_done: cover property (state_q == trace_pkg::CAP_POST ##[1:300] done_q);
  c_entry_read: cover property (psel && penable && paddr == `OFF_ESTAT);
endmodule
`default_nettype wire

// ---- verification/target_bus_model.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "trace_params.svh"
module target_bus_model (
  input wire logic pclk,
  output logic bus_cycle,
  output logic [`ADDR_W-1:0] tgt_addr,
  output logic [`DATA_W-1:0] tgt_data,
  output logic [`EXT_W-1:0] ext_probe,
  output logic [`STAT_W-1:0] proc_status
);
  int issued;
  initial
  begin
    issued = 0;
    bus_cycle = 1'b0;
    tgt_addr = 24'h0;
    tgt_data = 16'h0;
    ext_probe = 4'hF;
    proc_status = 20'h0;
  end
  // ----------------------------------------
  // One bus cycle; pins inverted when released
  // ----------------------------------------
  task cycle(input logic [23:0] a, input logic [15:0] d, input logic [3:0] e,
             input logic [19:0] s, input int hi, input int lo);
    @(posedge pclk);
    issued++;
    bus_cycle <= 1'b1;
    tgt_addr <= a;
    tgt_data <= d;
    ext_probe <= e;
    proc_status <= s;
    repeat (hi) @(posedge pclk);
    bus_cycle <= 1'b0;
    tgt_addr <= ~a;
    tgt_data <= ~d;
    ext_probe <= ~e;
    proc_status <= ~s;
    repeat (lo) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// ---- verification/trace_trigger_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "trace_params.svh"
`define CHK(got, exp) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) \
    begin \
      fail_count++; \
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp); \
    end \
  end
module trace_trigger_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic bus_cycle, break_req, trace_done;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdata, rnd;
  logic [`ADDR_W-1:0] tgt_addr;
  logic [`DATA_W-1:0] tgt_data;
  logic [`EXT_W-1:0] ext_probe;
  logic [`STAT_W-1:0] proc_status;
  logic [1:0] snap_scope;
  logic [3:0] pen;
  logic [63:0] q[$];
  int fail_count, num_checks, brk_n, brk_at, t, el;
  trace_trigger trace_trigger_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus_cycle(bus_cycle),
    .tgt_addr(tgt_addr), .tgt_data(tgt_data), .ext_probe(ext_probe),
    .proc_status(proc_status), .break_req(break_req), .snap_scope(snap_scope),
    .trace_done(trace_done));
  target_bus_model target_bus_model_i (.pclk(pclk), .bus_cycle(bus_cycle),
    .tgt_addr(tgt_addr), .tgt_data(tgt_data), .ext_probe(ext_probe),
    .proc_status(proc_status));
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk)
    if (break_req === 1'b1)
    begin
      brk_n++;
      brk_at = target_bus_model_i.issued;
    end
  initial
  begin
    repeat (100000) @(posedge pclk);
    fail_count++;
    conclude();
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = s[0] ? ((s >> 1) ^ 32'hA3000000) : (s >> 1);
  endfunction
  task conclude();
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
    begin
      fail_count++;
      conclude();
    end
  endtask
  task bus(input logic [23:0] a);
    logic [19:0] s;
    rnd = lfsr(rnd);
    s = rnd[31:12];
    rnd = lfsr(rnd);
    q.push_back({rnd[31:28], s, rnd[15:0], a});
    target_bus_model_i.cycle(a, rnd[15:0], rnd[31:28], s, 3 + rnd[20], 3 + rnd[21]);
  endtask
  task rand_bus(input int n);
    repeat (n)
    begin
      rnd = lfsr(rnd);
      bus({1'b0, rnd[22:0]});
    end
  endtask
  task check_run(input int trig, input int post);
    logic [63:0] e;
    logic [19:0] nib;
    logic [1:0] k;
    logic [15:0] dm;
    for (int p = -6; p <= post; p++)
    begin
      e = q[trig + p];
      for (int n = 0; n < 5; n++)
        nib[(4 - n) * 4 +: 4] = e[40 + n * 4 +: 4];
      k = e[42] ? 2'h2 : (e[41] ? 2'h1 : 2'h0);
      dm = e[43] ? e[39:24] : {8'h0, e[31:24]};
      apb(1'b1, 8'h10, {24'h0, 8'(p)});
      apb(1'b0, 8'h14, 32'h0);
      `CHK(rdata, {8'h0, e[23:0]})
      apb(1'b0, 8'h18, 32'h0);
      `CHK(rdata, {8'h0, e[63:60] | ~pen, 2'h0, k, dm})
      apb(1'b0, 8'h1C, 32'h0);
      `CHK(rdata, {12'h0, nib})
    end
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = 43'h0;
    fail_count = 0;
    num_checks = 0;
    brk_n = 0;
    rnd = 32'h43;
    presetn = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    `CHK(snap_scope, 2'h1)
    apb(1'b0, 8'h00, 32'h0);
    `CHK(rdata, 32'h2)
    apb(1'b0, 8'h08, 32'h0);
    `CHK(rdata, 32'h0)
    for (int s = 0; s < 3; s++)
    begin
      apb(1'b1, 8'h00, 32'(s * 2));
      @(posedge pclk);
      `CHK(snap_scope, s[1:0])
    end
    apb(1'b0, 8'h2C, 32'h0);
    `CHK({rerr, rdata}, 33'h100000000)
    apb(1'b0, 8'h01, 32'h0);
    `CHK({rerr, rdata}, 33'h100000000)
    // OR mode, probes unconnected, qualifier hit first
    pen = 4'h0;
    apb(1'b1, 8'h28, 32'h0);
    apb(1'b1, 8'h30, 32'h800123);
    apb(1'b1, 8'h31, 32'h5);
    `CHK(rerr, 1'b1)
    apb(1'b0, 8'h30, 32'h0);
    `CHK(rdata, 32'h800123)
    apb(1'b1, 8'h40, 32'h0);
    apb(1'b1, 8'h3C, 32'h800777);
    apb(1'b1, 8'h4C, 32'h0);
    apb(1'b1, 8'h24, 32'h9);
    apb(1'b1, 8'h0C, 32'h4);
    apb(1'b1, 8'h00, 32'hA);
    rand_bus(8);
    bus(24'h800777);
    rand_bus(3);
    t = q.size();
    bus(24'h800123);
    rand_bus(6);
    `CHK(trace_done, 1'b1)
    `CHK(brk_n, 1)
    `CHK(brk_at, t + 5)
    apb(1'b0, 8'h08, 32'h0);
    `CHK(rdata & 32'hC3, 32'hC2)
    check_run(t, 4);
    // AND chain with event timer in bus cycles
    apb(1'b1, 8'h00, 32'h0);
    pen = 4'hF;
    apb(1'b1, 8'h28, 32'hF);
    apb(1'b1, 8'h34, 32'h800200);
    apb(1'b1, 8'h44, 32'h0);
    apb(1'b1, 8'h38, 32'h800300);
    apb(1'b1, 8'h48, 32'h0);
    apb(1'b1, 8'h24, 32'h7);
    apb(1'b1, 8'h0C, 32'h3);
    brk_n = 0;
    apb(1'b1, 8'h00, 32'h59);
    rand_bus(6);
    bus(24'h800300);
    rand_bus(2);
    bus(24'h800123);
    rand_bus(2);
    bus(24'h800200);
    rand_bus(5);
    t = q.size();
    bus(24'h800300);
    rand_bus(5);
    `CHK(brk_n, 1)
    `CHK(brk_at, t + 4)
    check_run(t, 3);
    apb(1'b0, 8'h20, 32'h0);
    `CHK(rdata >= 5 && rdata <= 7, 1'b1)
    // Event timer in 100 ns units
    apb(1'b1, 8'h00, 32'h39);
    bus(24'h800123);
    t = int'($time);
    bus(24'h800200);
    rand_bus(4);
    el = int'($time) - t;
    bus(24'h800300);
    apb(1'b0, 8'h20, 32'h0);
    `CHK(el > rdata * 100 && el <= rdata * 100 + 100, 1'b1)
    conclude();
  end
endmodule
`default_nettype wire
